/* File: hw/pia_defines.svh */
// Constants of the PHY indirect access and status block.
// Assumes inclusion by bare name from the engine and top design files.
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH

// Register offsets on the management link
`define PIA_OFS_CTRL 5'h0D
`define PIA_OFS_WIN  5'h0E
`define PIA_OFS_STAT 5'h10
`define PIA_OFS_FCC  5'h14
`define PIA_OFS_REC  5'h15
`define PIA_OFS_TMS  5'h1A

// Field positions
`define PIA_FUNC_HI  15
`define PIA_FUNC_LO  14
`define PIA_DEV_HI   4
`define PIA_ST_MDIX  14
`define PIA_ST_RXERR 13
`define PIA_ST_POL   12
`define PIA_ST_FCS   11

// Values and reset values
`define PIA_VALID_DEV 5'h1F
`define PIA_RST_DEV   5'h00
`define PIA_RST_PTR   16'h0000

// Frame timing in link clocks, and operation codes
`define PIA_PRE_LEN  6'h20
`define PIA_LAST_BIT 6'h0F
`define PIA_OP_RD    2'h2
`define PIA_OP_WR    2'h1

`endif

/* File: hw/pia_pkg.sv */
// Types shared by the PHY indirect access and status block.
// Assumes nothing of its surroundings.
package pia_pkg;

  // Window function field
  typedef enum logic [1:0] {
    fn_addr   = 2'b00,
    fn_data   = 2'b01,
    fn_inc_rw = 2'b10,
    fn_inc_w  = 2'b11
  } pia_func_t;

  // Serial frame position
  typedef enum logic [2:0] {
    fr_pre = 3'b000,
    fr_st  = 3'b001,
    fr_op  = 3'b010,
    fr_phy = 3'b011,
    fr_reg = 3'b100,
    fr_ta  = 3'b101,
    fr_dat = 3'b110
  } pia_frame_t;

endpackage : pia_pkg

/* File: hw/pia_mgmt_if.sv */
// Request and answer path between the frame engine and the register bank.
// Assumes both ends run on the link clock.
`timescale 1ns/10ps
`default_nettype none
interface pia_mgmt_if;
  logic        rd_req;   // One-cycle read request
  logic        wr_req;   // One-cycle write request
  logic [4:0]  reg_addr; // Register offset
  logic [15:0] wdata;    // Write data
  logic [15:0] rdata;    // Read data, valid one cycle after rd_req

  modport engine (output rd_req, wr_req, reg_addr, wdata, input rdata);
  modport bank   (input rd_req, wr_req, reg_addr, wdata, output rdata);
endinterface : pia_mgmt_if
`default_nettype wire

/* File: hw/pia_mdio_engine.sv */
// Serial management frame engine on the link clock.
// Assumes the host changes the data line while its clock is low, ahead of the rising edge.
`timescale 1ns/10ps
`default_nettype none
`include "pia_defines.svh"
module pia_mdio_engine #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Link clock and reset
  input  wire logic   mdc_clk_in,
  input  wire logic   mdc_rst_n_in,
  // Data line
  input  wire logic   mdio_in,
  output var  logic   mdio_out,
  output var  logic   mdio_oe_out,
  // Register bank side
  pia_mgmt_if.engine  mgmt
);

  pia_pkg::pia_frame_t state_reg; // Frame position
  logic [5:0]          cnt_reg;   // Bit counter
  logic [1:0]          op_reg;    // Operation code
  logic [4:0]          phy_reg;   // Station address
  logic [4:0]          addr_reg;  // Register offset
  logic [15:0]         shift_reg; // Data shifter
  logic                rd_reg;    // Read request pulse
  logic                wr_reg;    // Write request pulse
  logic                reading;   // This frame reads us
  logic                writing;   // This frame writes us

  assign reading = (op_reg == `PIA_OP_RD) && (phy_reg == PHY_ADDR);
  assign writing = (op_reg == `PIA_OP_WR) && (phy_reg == PHY_ADDR);
  assign mgmt.rd_req   = rd_reg;
  assign mgmt.wr_req   = wr_reg;
  assign mgmt.reg_addr = addr_reg;
  assign mgmt.wdata    = shift_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame walk: preamble, start, opcode, addresses, turnaround, data
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n_in) begin
    if (!mdc_rst_n_in) begin
      state_reg   <= pia_pkg::fr_pre;
      cnt_reg     <= 6'h00;
      op_reg      <= 2'h0;
      phy_reg     <= 5'h00;
      addr_reg    <= 5'h00;
      shift_reg   <= 16'h0000;
      rd_reg      <= 1'b0;
      wr_reg      <= 1'b0;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      unique case (state_reg)
        pia_pkg::fr_pre: begin
          // Count ones; a zero after a full preamble starts a frame
          if (mdio_in) begin
            if (cnt_reg != `PIA_PRE_LEN) cnt_reg <= cnt_reg + 6'h01;
          end else if (cnt_reg == `PIA_PRE_LEN) begin
            state_reg <= pia_pkg::fr_st;
            cnt_reg   <= 6'h00;
          end else begin
            cnt_reg <= 6'h00;
          end
        end
        pia_pkg::fr_st: begin
          // Second start bit must be one
          state_reg <= mdio_in ? pia_pkg::fr_op : pia_pkg::fr_pre;
          cnt_reg   <= 6'h00;
        end
        pia_pkg::fr_op: begin
          op_reg  <= {op_reg[0], mdio_in};
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h01) begin
            state_reg <= pia_pkg::fr_phy;
            cnt_reg   <= 6'h00;
          end
        end
        pia_pkg::fr_phy: begin
          phy_reg <= {phy_reg[3:0], mdio_in};
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h04) begin
            state_reg <= pia_pkg::fr_reg;
            cnt_reg   <= 6'h00;
          end
        end
        pia_pkg::fr_reg: begin
          // Read is requested as soon as the offset is complete
          addr_reg <= {addr_reg[3:0], mdio_in};
          cnt_reg  <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h04) begin
            state_reg <= pia_pkg::fr_ta;
            cnt_reg   <= 6'h00;
            rd_reg    <= reading;
          end
        end
        pia_pkg::fr_ta: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h00) begin
            // Drive the zero turnaround bit on reads
            mdio_oe_out <= reading;
            mdio_out    <= 1'b0;
          end else begin
            state_reg <= pia_pkg::fr_dat;
            cnt_reg   <= 6'h00;
            shift_reg <= {mgmt.rdata[14:0], 1'b0};
            mdio_out  <= reading & mgmt.rdata[15];
          end
        end
        pia_pkg::fr_dat: begin
          // Shift both ways; the unused direction is harmless
          shift_reg <= {shift_reg[14:0], mdio_in};
          mdio_out  <= reading & shift_reg[15];
          cnt_reg   <= cnt_reg + 6'h01;
          if (cnt_reg == `PIA_LAST_BIT) begin
            state_reg   <= pia_pkg::fr_pre;
            cnt_reg     <= 6'h00;
            mdio_oe_out <= 1'b0;
            wr_reg      <= writing;
          end
        end
        default: begin
          state_reg <= pia_pkg::fr_pre;
          cnt_reg   <= 6'h00;
        end
      endcase
    end
  end

  // Line is released outside the turnaround and data phases of reads
  oe_release_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n_in)
    (state_reg == pia_pkg::fr_pre) && !$past(state_reg == pia_pkg::fr_dat) |-> !mdio_oe_out)
    else $error("data line driven outside a read");

endmodule : pia_mdio_engine
`default_nettype wire

/* File: hw/pia_top.sv */
// Indirect extended register access and status summary of a PHY.
// Assumes event inputs come from other clocks and the link clock may stop.
`timescale 1ns/10ps
`default_nettype none
`include "pia_defines.svh"
module pia_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clocks, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        core_clk_en_in,
  input  wire logic        mdc_clk_in,
  // Management data line
  input  wire logic        mdio_in,
  output var  logic        mdio_out,
  output var  logic        mdio_oe_out,
  // Line events and crossover settings
  input  wire logic        rx_error_in,
  input  wire logic        false_carrier_in,
  input  wire logic        polarity_inverted_in,
  input  wire logic        auto_crossover_enable_in,
  input  wire logic        force_crossover_in,
  input  wire logic        mdix_algo_swapped_in,
  // Extended register set, link clock domain
  output var  logic [15:0] ext_addr_out,
  output var  logic [15:0] ext_wdata_out,
  output var  logic        ext_wr_out,
  output var  logic        ext_rd_out,
  input  wire logic [15:0] ext_rdata_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]  rst_core_reg;   // Core reset release
  logic [1:0]  rst_mdc_reg;    // Link reset release
  logic        core_rst_n;     // Core domain reset
  logic        mdc_rst_n;      // Link domain reset
  logic [5:0]  in_meta_reg;    // Input synchroniser, first stage
  logic [5:0]  in_sync_reg;    // Input synchroniser, second stage
  logic [1:0]  evt_prev_reg;   // Edge detect for error events
  logic        rx_evt;         // Receive error edge
  logic        fc_evt;         // False carrier edge
  logic [2:0]  clr_meta_reg;   // Clear toggles, first stage
  logic [2:0]  clr_sync_reg;   // Clear toggles, second stage
  logic [2:0]  clr_prev_reg;   // Clear toggles, last seen
  logic [2:0]  clr_pulse;      // Clear requests: 0 carrier, 1 error, 2 polarity
  logic        rxerr_lat_reg;  // Receive error latch
  logic        fcs_lat_reg;    // False carrier latch
  logic        pol_lat_reg;    // Polarity latch
  logic        mdix_reg;       // Pair swap state
  logic [3:0]  st_meta_reg;    // Status into link domain, first stage
  logic [3:0]  st_sync_reg;    // Status into link domain, second stage
  pia_pkg::pia_func_t func_reg; // Window function
  logic [4:0]  target_device_address_reg;      // Target device address
  logic [15:0] rdata_reg;      // Read answer
  logic [15:0] rd_val;         // Read mux
  logic [2:0]  clr_tgl_reg;    // Clear toggles toward core
  logic        win_acc;        // Window access
  logic        win_ok;         // Device address accepted
  logic        ptr_inc;        // Post-increment due

  pia_mgmt_if mgmt ();

  assign core_rst_n = rst_core_reg[1];
  assign mdc_rst_n  = rst_mdc_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset release in each domain
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rst_core_reg <= 2'b00;
    else           rst_core_reg <= {rst_core_reg[0], 1'b1};
  end

  always_ff @(posedge mdc_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rst_mdc_reg <= 2'b00;
    else           rst_mdc_reg <= {rst_mdc_reg[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine
  pia_mdio_engine #(
    .PHY_ADDR     (PHY_ADDR)
  ) u_engine (
    .mdc_clk_in   (mdc_clk_in),
    .mdc_rst_n_in (mdc_rst_n),
    .mdio_in      (mdio_in),
    .mdio_out     (mdio_out),
    .mdio_oe_out  (mdio_oe_out),
    .mgmt         (mgmt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronise line inputs and clear toggles
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      in_meta_reg  <= 6'h00;
      in_sync_reg  <= 6'h00;
      evt_prev_reg <= 2'h0;
      clr_meta_reg <= 3'h0;
      clr_sync_reg <= 3'h0;
      clr_prev_reg <= 3'h0;
    end else if (core_clk_en_in) begin
      in_meta_reg  <= {mdix_algo_swapped_in, force_crossover_in,
                       auto_crossover_enable_in, polarity_inverted_in,
                       false_carrier_in, rx_error_in};
      in_sync_reg  <= in_meta_reg;
      evt_prev_reg <= in_sync_reg[1:0];
      clr_meta_reg <= clr_tgl_reg;
      clr_sync_reg <= clr_meta_reg;
      clr_prev_reg <= clr_sync_reg;
    end
  end

  assign rx_evt    = in_sync_reg[0] & ~evt_prev_reg[0];
  assign fc_evt    = in_sync_reg[1] & ~evt_prev_reg[1];
  assign clr_pulse = clr_sync_reg ^ clr_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: status latches, a new event beats a clear
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rxerr_lat_reg <= 1'b0;
      fcs_lat_reg   <= 1'b0;
      pol_lat_reg   <= 1'b0;
    end else if (core_clk_en_in) begin
      rxerr_lat_reg <= rx_evt | (rxerr_lat_reg & ~clr_pulse[1]);
      fcs_lat_reg   <= fc_evt | (fcs_lat_reg & ~clr_pulse[0]);
      pol_lat_reg   <= in_sync_reg[2] | (pol_lat_reg & ~clr_pulse[2]);
    end
  end

  // Pair swap: forced swap wins, else the algorithm when enabled
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      mdix_reg <= 1'b0;
    end else if (core_clk_en_in) begin
      mdix_reg <= in_sync_reg[4] | (in_sync_reg[3] & in_sync_reg[5]);
    end
  end

  rxerr_set_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && rx_evt |=> rxerr_lat_reg)
    else $error("receive error not latched");
  fcs_clear_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && clr_pulse[0] && !fc_evt |=> !fcs_lat_reg)
    else $error("false carrier latch not cleared");
  pol_hold_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && pol_lat_reg && !clr_pulse[2] |=> pol_lat_reg)
    else $error("polarity latch dropped without clear");
  mdix_force_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && in_sync_reg[4] |=> mdix_reg)
    else $error("forced swap not shown");

  // Clears must take, polarity must set, swap must track the algorithm
  rxerr_clear_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && clr_pulse[1] && !rx_evt |=> !rxerr_lat_reg)
    else $error("receive error latch not cleared");
  pol_set_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && in_sync_reg[2] |=> pol_lat_reg)
    else $error("polarity latch not set");
  swap_follow_a: assert property (@(posedge core_clk_in) disable iff (!core_rst_n)
    core_clk_en_in && in_sync_reg[3] && !in_sync_reg[4] |=> mdix_reg == $past(in_sync_reg[5]))
    else $error("swap bit not following the algorithm");

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: status levels cross in through two flops
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) begin
      st_meta_reg <= 4'h0;
      st_sync_reg <= 4'h0;
    end else begin
      st_meta_reg <= {mdix_reg, rxerr_lat_reg, pol_lat_reg, fcs_lat_reg};
      st_sync_reg <= st_meta_reg;
    end
  end

  // Window decode and the post-increment decision
  assign win_acc = (mgmt.rd_req | mgmt.wr_req) && (mgmt.reg_addr == `PIA_OFS_WIN);
  assign win_ok  = (target_device_address_reg == `PIA_VALID_DEV);
  assign ptr_inc = win_acc && win_ok && ((func_reg == pia_pkg::fn_inc_rw)
                   || (func_reg == pia_pkg::fn_inc_w && mgmt.wr_req));

  ////////////////////////////////////////////////////////////////////////////
  // Access control register, reserved bits not stored
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) begin
      func_reg  <= pia_pkg::fn_addr;
      target_device_address_reg <= `PIA_RST_DEV;
    end else if (mgmt.wr_req && mgmt.reg_addr == `PIA_OFS_CTRL) begin
      func_reg  <= pia_pkg::pia_func_t'(mgmt.wdata[`PIA_FUNC_HI:`PIA_FUNC_LO]);
      target_device_address_reg <= mgmt.wdata[`PIA_DEV_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extended address pointer: load in address mode, post-increment
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) begin
      ext_addr_out <= `PIA_RST_PTR;
    end else if (win_acc && win_ok && mgmt.wr_req && func_reg == pia_pkg::fn_addr) begin
      ext_addr_out <= mgmt.wdata;
    end else if (ptr_inc) begin
      ext_addr_out <= ext_addr_out + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extended register strobes for window accesses in data and both increment modes
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) begin
      ext_wr_out    <= 1'b0;
      ext_rd_out    <= 1'b0;
      ext_wdata_out <= 16'h0000;
    end else begin
      ext_wr_out <= win_acc && win_ok && mgmt.wr_req && func_reg != pia_pkg::fn_addr;
      ext_rd_out <= win_acc && win_ok && mgmt.rd_req && func_reg != pia_pkg::fn_addr;
      if (win_acc && win_ok && mgmt.wr_req) ext_wdata_out <= mgmt.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux: reserved and unmapped bits read zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (mgmt.reg_addr)
      `PIA_OFS_CTRL: begin
        rd_val[`PIA_FUNC_HI:`PIA_FUNC_LO] = func_reg;
        rd_val[`PIA_DEV_HI:0]             = target_device_address_reg;
      end
      `PIA_OFS_WIN: begin
        if (win_ok && func_reg == pia_pkg::fn_addr) rd_val = ext_addr_out;
        else if (win_ok) rd_val = ext_rdata_in;
      end
      `PIA_OFS_STAT: begin
        rd_val[`PIA_ST_MDIX]  = st_sync_reg[3];
        rd_val[`PIA_ST_RXERR] = st_sync_reg[2];
        rd_val[`PIA_ST_POL]   = st_sync_reg[1];
        rd_val[`PIA_ST_FCS]   = st_sync_reg[0];
      end
      default: rd_val = 16'h0000;
    endcase
  end

  // Answer is held for the engine's turnaround load
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) rdata_reg <= 16'h0000;
    else if (mgmt.rd_req) rdata_reg <= rd_val;
  end

  // Engine loads this at the second turnaround edge
  assign mgmt.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter reads send clear toggles to the core latches
  always_ff @(posedge mdc_clk_in or negedge mdc_rst_n) begin
    if (!mdc_rst_n) begin
      clr_tgl_reg <= 3'h0;
    end else if (mgmt.rd_req) begin
      if (mgmt.reg_addr == `PIA_OFS_FCC) clr_tgl_reg[0] <= ~clr_tgl_reg[0];
      if (mgmt.reg_addr == `PIA_OFS_REC) clr_tgl_reg[1] <= ~clr_tgl_reg[1];
      if (mgmt.reg_addr == `PIA_OFS_TMS) clr_tgl_reg[2] <= ~clr_tgl_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain checks
  ctrl_func_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    mgmt.wr_req && mgmt.reg_addr == `PIA_OFS_CTRL |=> func_reg == $past(mgmt.wdata[15:14]))
    else $error("function field not stored");
  // Control reserves 13:5, status reserves 15; status 14:11 carry live bits
  ctrl_res_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    mgmt.rd_req && (mgmt.reg_addr == `PIA_OFS_CTRL || mgmt.reg_addr == `PIA_OFS_STAT)
    |=> (($past(mgmt.reg_addr) == `PIA_OFS_CTRL) ? (rdata_reg[13:5] == 9'h000)
                                                   : !rdata_reg[15]))
    else $error("reserved bits read nonzero");
  target_device_address_gate_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && !win_ok |=> $stable(ext_addr_out) && !ext_wr_out && !ext_rd_out)
    else $error("window used with wrong device address");
  addr_load_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && win_ok && mgmt.wr_req && func_reg == pia_pkg::fn_addr
    |=> ext_addr_out == $past(mgmt.wdata) && !ext_wr_out)
    else $error("pointer not loaded");
  no_inc_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && win_ok && func_reg == pia_pkg::fn_data |=> $stable(ext_addr_out))
    else $error("pointer moved without increment mode");
  inc_rw_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && win_ok && func_reg == pia_pkg::fn_inc_rw
    |=> ext_addr_out == $past(ext_addr_out) + 16'h0001)
    else $error("pointer not incremented");
  inc_w_rd_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && win_ok && func_reg == pia_pkg::fn_inc_w && mgmt.rd_req
    |=> $stable(ext_addr_out) && ext_rd_out)
    else $error("pointer moved on read in write-increment mode");
  // Write in write-increment mode strobes and advances on the same edge, wrapping at the top
  inc_w_wr_a: assert property (@(posedge mdc_clk_in) disable iff (!mdc_rst_n)
    win_acc && win_ok && func_reg == pia_pkg::fn_inc_w && mgmt.wr_req
    |=> ext_addr_out == $past(ext_addr_out) + 16'h0001 && ext_wr_out)
    else $error("pointer not incremented after write");

endmodule : pia_top
`default_nettype wire

/* File: dv/pia_host_model.sv */
// Management host model: frames on the serial data line.
// Assumes the bench resolves the line with a pull-up when nobody drives.
`timescale 1ns/10ps
`default_nettype none
module pia_host_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Link clock and data line towards the device
  output var  logic mdc_clk_out,
  output var  logic mdio_d_out,
  output var  logic mdio_oe_out,
  // Resolved line level
  input  wire logic mdio_in
);
  // Clock stands low and line released between frames
  initial begin
    mdc_clk_out = 1'b0;
    mdio_d_out  = 1'b1;
    mdio_oe_out = 1'b0;
  end
  // One period: data set while low, line sampled just before the rise
  task automatic tick(input logic d, input logic oe, output logic s);
    mdio_d_out  = d;
    mdio_oe_out = oe;
    #62.5;
    s           = mdio_in;
    mdc_clk_out = 1'b1;
    #62.5;
    mdc_clk_out = 1'b0;
  endtask : tick
  // Whole frame; long preamble also covers the reset synchroniser ticks
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [49:0] hdr;
    logic        s;
    hdr = {36'hFFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, PHY_ADDR, ra};
    #37;
    for (int i = 49; i >= 0; i--) tick(hdr[i], 1'b1, s);
    // Turnaround: released on reads so the device can take the line
    tick(1'b1, ~rd, s);
    tick(1'b0, ~rd, s);
    for (int i = 15; i >= 0; i--) begin
      tick(wd[i], ~rd, s);
      rdat[i] = s;
    end
    // Trailing ticks let the internal write strobes land
    repeat (2) tick(1'b1, 1'b0, s);
  endtask : xfer
endmodule : pia_host_model
`default_nettype wire

/* File: dv/test_phy_indirect_access_and_status.sv */
// Bench: reset test, table of frames with line events, then a second reset test.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define TB_CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h seen %h", n, e, v); end end
module test_phy_indirect_access_and_status;
  // Row: events {rxerr, fcar, pol, en, force, algo}, read, offset, wdata, expected
  typedef struct packed {
    logic [5:0]  ev;
    logic        rd;
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [15:0] ex;
  } pia_row_t;
  localparam pia_row_t ROWS [32] = '{
    '{6'h00, 1'b0, 5'h0D, 16'h001F, 16'h0000}, '{6'h00, 1'b0, 5'h0E, 16'hFFFF, 16'h0000},
    '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'hFFFF}, '{6'h00, 1'b1, 5'h0D, 16'h0000, 16'h001F},
    '{6'h00, 1'b0, 5'h0D, 16'hFFFF, 16'h0000}, '{6'h00, 1'b1, 5'h0D, 16'h0000, 16'hC01F},
    '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'h5A3C}, '{6'h00, 1'b0, 5'h0E, 16'h1234, 16'h0000},
    '{6'h00, 1'b0, 5'h0D, 16'h801F, 16'h0000}, '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'hA5C3},
    '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'hA5C2}, '{6'h00, 1'b0, 5'h0D, 16'h401F, 16'h0000},
    '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'hA5C1}, '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'hA5C1},
    '{6'h00, 1'b0, 5'h0D, 16'h0000, 16'h0000}, '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'h0000},
    '{6'h00, 1'b0, 5'h0E, 16'h5555, 16'h0000}, '{6'h00, 1'b0, 5'h0D, 16'h001F, 16'h0000},
    '{6'h00, 1'b1, 5'h0E, 16'h0000, 16'h0002}, '{6'h00, 1'b1, 5'h11, 16'h0000, 16'h0000},
    '{6'h00, 1'b0, 5'h10, 16'hFFFF, 16'h0000}, '{6'h3A, 1'b1, 5'h10, 16'h0000, 16'h7800},
    '{6'h02, 1'b1, 5'h10, 16'h0000, 16'h7800}, '{6'h02, 1'b1, 5'h15, 16'h0000, 16'h0000},
    '{6'h02, 1'b1, 5'h10, 16'h0000, 16'h5800}, '{6'h02, 1'b1, 5'h14, 16'h0000, 16'h0000},
    '{6'h02, 1'b1, 5'h10, 16'h0000, 16'h5000}, '{6'h02, 1'b1, 5'h1A, 16'h0000, 16'h0000},
    '{6'h02, 1'b1, 5'h10, 16'h0000, 16'h4000}, '{6'h05, 1'b1, 5'h10, 16'h0000, 16'h4000},
    '{6'h04, 1'b1, 5'h10, 16'h0000, 16'h0000}, '{6'h01, 1'b1, 5'h10, 16'h0000, 16'h0000}};
  logic        core_clk, rst_n, mdc, h_d, h_oe, mdio_w, mdio_out, mdio_oe;
  logic        ext_wr, ext_rd;
  logic [5:0]  ev;
  logic [15:0] ext_addr, ext_wdata, ext_rdata, rdat, last_wd;
  int          fail_count, num_checks, cyc, wr_cnt, rd_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, pull-up line resolution, extended register content
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  assign mdio_w    = mdio_oe ? mdio_out : (h_oe ? h_d : 1'b1);
  assign ext_rdata = ext_addr ^ 16'hA5C3;
  pia_host_model host (.mdc_clk_out(mdc), .mdio_d_out(h_d), .mdio_oe_out(h_oe),
                       .mdio_in(mdio_w));
  pia_top dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .core_clk_en_in(1'b1), .mdc_clk_in(mdc),
    .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe),
    .rx_error_in(ev[5]), .false_carrier_in(ev[4]), .polarity_inverted_in(ev[3]),
    .auto_crossover_enable_in(ev[2]), .force_crossover_in(ev[1]),
    .mdix_algo_swapped_in(ev[0]), .ext_addr_out(ext_addr), .ext_wdata_out(ext_wdata),
    .ext_wr_out(ext_wr), .ext_rd_out(ext_rd), .ext_rdata_in(ext_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // Strobe monitor at the falling link edge, clear of update races
  always @(negedge mdc) begin
    if (ext_wr === 1'b1) begin
      wr_cnt++;
      last_wd = ext_wdata;
    end
    if (ext_rd === 1'b1) rd_cnt++;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Hang guard, far above the expected few thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b1;
    ev    = 6'h00;
    // A real falling edge makes the asynchronous resets take hold
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    `TB_CHK("line enable in reset", 1'b0, mdio_oe)
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk);
      ev <= ROWS[i].ev;
      repeat (12) @(posedge core_clk);
      host.xfer(ROWS[i].rd, ROWS[i].ra, ROWS[i].wd, rdat);
      if (ROWS[i].rd)
        `TB_CHK("read data", ROWS[i].ex, rdat)
      $display("row %0d done", i);
    end
    `TB_CHK("data writes", 1, wr_cnt)
    `TB_CHK("write data", 16'h1234, last_wd)
    `TB_CHK("data reads", 5, rd_cnt)
    $display("strobe test done");
    // Second reset in mid-run clears pointer and control
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    `TB_CHK("pointer in reset", 16'h0000, ext_addr)
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    host.xfer(1'b1, 5'h0D, 16'h0000, rdat);
    `TB_CHK("control after reset", 16'h0000, rdat)
    $display("second reset test done");
    test_done();
  end
endmodule : test_phy_indirect_access_and_status
`default_nettype wire
